// File: common/capture_ctrl_map.vh
// offsets, fields, reset values and timing counts of the capture control unit
`ifndef CAPTURE_CTRL_MAP_VH
`define CAPTURE_CTRL_MAP_VH
`define PORT_CONTROL        1'b0
`define PORT_DATA           1'b1
`define CW_WRITE            0
`define CW_ARM              1
`define CW_GAIN_X2          2
`define CW_VTRIG_POL        3
`define CW_SAMPLE_DIS_N     4
`define CW_ADC_WRITE_DIS_N  5
`define CW_ADDR_LOAD_N      6
`define CW_POST_LOAD_N      7
`define CW_VTRIG_EN_N       8
`define CW_READ_CLK_N       9
`define CW_MEM_READ_N       10
`define CW_TADDR_READ_N     11
`define CW_RATE_LOAD_N      12
`define CW_SWEEP_REL_N      13
`define CW_VLEVEL_LOAD_N    14
`define CW_PIT_SELECT       15
`define CW_RESET            16'hfff0
`define REF_CLK_MHZ         24
`define FULL_RATE_MHZ       12
`define FULL_RATE_DIV       (`REF_CLK_MHZ / `FULL_RATE_MHZ)
`define ADDR_WRAP           15'h7fff
`define POST_TERMINAL       16'hffff
`endif

// File: core/rate_generator.v
// sample-rate generator: bucket and sample clock enables from the reference
`timescale 1ns/1ns
`include "capture_ctrl_map.vh"
module rate_generator #(
   parameter RATE_W = 8
) (
   input  wire              sys_clk,
   input  wire              arst_n,
   input  wire              run,
   input  wire [RATE_W-1:0] rate_code,
   output reg               sample_tick_ff,
   output reg               bucket_tick_ff,
   output reg               full_rate_ff
);
   reg [1:0]        ref_div_ff;
   reg [RATE_W-1:0] bucket_cnt_ff;
   wire             ref_tick;

   // 12 MHz sample tick from 24 MHz reference
   assign ref_tick = ({30'h0, ref_div_ff} == (`FULL_RATE_DIV - 1));

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ref_div_ff     <= 2'h0;
         bucket_cnt_ff  <= {RATE_W{1'b0}};
         sample_tick_ff <= 1'b0;
         bucket_tick_ff <= 1'b0;
         full_rate_ff   <= 1'b1;
      end else begin
         full_rate_ff   <= (rate_code == {RATE_W{1'b0}}); // R12
         if (!run) begin // R21
            ref_div_ff     <= 2'h0;
            bucket_cnt_ff  <= {RATE_W{1'b0}};
            sample_tick_ff <= 1'b0;
            bucket_tick_ff <= 1'b0;
         end else begin
            ref_div_ff     <= ref_tick ? 2'h0 : ref_div_ff + 2'h1; // R11
            sample_tick_ff <= ref_tick;
            // rate_code+1 samples form one bucket, 1..256
            if (ref_tick) begin
               if (bucket_cnt_ff == rate_code) begin // R12
                  bucket_cnt_ff  <= {RATE_W{1'b0}};
                  bucket_tick_ff <= 1'b1;
               end else begin
                  bucket_cnt_ff  <= bucket_cnt_ff + {{(RATE_W-1){1'b0}}, 1'b1};
                  bucket_tick_ff <= 1'b0;
               end
            end else begin
               bucket_tick_ff <= 1'b0;
            end
         end
      end
   end
endmodule // rate_generator

// File: core/capture_control.v
// fast capture control: control word, counters, trigger and host read path
`timescale 1ns/1ns
`include "capture_ctrl_map.vh"
// Notes on behaviour
// R1 - bit 6 low lets host load address counter
// R2 - bit 7 low lets host load post counter
// R3 - bit 8 low enables video trigger
// R4 - bit 9 low enables read clock
// R5 - bit 10 low lets host read memory
// R6 - bit 11 low drives trigger address out
// R7 - bit 12 low lets host write rate latch
// R8 - bit 13 low releases sweep strobe
// R9 - bit 14 low loads video trigger level
// R10 - bit 15 picks pit over peak detection
// R11 - all clocks derived from 24 MHz reference
// R12 - one to 256 samples per bucket
// R13 - bucket start forces first sample stored
// R14 - trigger latches address, starts post counter
// R15 - writes continue until post terminal count
// R16 - arm enables; rearm needs low then high
// R17 - sweep strobe or video clock triggers
// R18 - video trigger synchronous to sample clock
// R20 - host reads trigger address, reloads counter
// R21 - write bit runs clocks, blocks reads
// R22 - control at primary, high byte first
// R23 - terminal count drives stop, halts counting
// R24 - address counter wraps 32767 to 0
// R25 - reset leaves enables high, disarmed
module capture_control #(
   parameter RATE_W = 8
) (
   input  wire       sys_clk,
   input  wire       arst_n,
   input  wire       port_select_line,
   input  wire       high_byte_strobe,
   input  wire       low_byte_strobe,
   input  wire [7:0] host_data_in,
   output reg  [7:0] host_data_out_ff,
   output reg        host_data_oe_ff,
   input  wire       sweep_strobe,
   input  wire [7:0] converter_sample,
   input  wire [7:0] mem_read_data,
   output reg  [7:0] mem_write_data_ff,
   output reg        mem_write_ff,
   output reg [14:0] mem_addr_ff,
   output reg        sweep_strobe_release_ff,
   output reg        count_stop_n_ff,
   output reg        video_trigger_clock_ff,
   output reg        triggered_ff,
   output reg        gain_x2_ff
);
   reg [15:0]       ctrl_word_ff;
   reg [7:0]        high_hold_ff;
   reg [7:0]        data_hi_ff;
   reg [RATE_W-1:0] rate_latch_ff;
   reg [7:0]        video_level_ff;
   reg [15:0]       post_cnt_ff;
   reg [14:0]       trig_addr_ff;
   reg [7:0]        extremum_ff;
   reg              counting_ff;
   reg              rearm_ok_ff;
   reg              sweep_d_ff;
   reg              above_d_ff;
   reg              hi_strobe_d_ff;
   reg              lo_strobe_d_ff;
   wire             sample_tick;
   wire             bucket_tick;
   wire             full_rate;
   wire             write_mode   = ctrl_word_ff[`CW_WRITE];
   wire             armed        = ctrl_word_ff[`CW_ARM];
   wire             read_clk_on  = !ctrl_word_ff[`CW_READ_CLK_N] && !write_mode; // R4
   wire             hi_pulse     = high_byte_strobe && !hi_strobe_d_ff;
   wire             lo_pulse     = low_byte_strobe && !lo_strobe_d_ff;
   wire             ctrl_wr      = lo_pulse && (port_select_line == `PORT_CONTROL);
   wire             data_lo      = lo_pulse && (port_select_line == `PORT_DATA);
   wire             data_hi      = hi_pulse && (port_select_line == `PORT_DATA);
   wire [15:0]      data_word    = {data_hi_ff, host_data_in};
   wire             mem_rd_on    = !ctrl_word_ff[`CW_MEM_READ_N] && !write_mode; // R5
   wire             taddr_rd_on  = !ctrl_word_ff[`CW_TADDR_READ_N]; // R6
   wire             above        = converter_sample > video_level_ff;
   wire             below        = converter_sample < video_level_ff;
   wire             video_edge;
   wire             trig_src;
   wire             trigger;
   wire             store;
   wire             take_new;

   rate_generator #(
      .RATE_W (RATE_W)
   ) i_rate_generator (
      .sys_clk        (sys_clk),
      .arst_n         (arst_n),
      .run            (write_mode),
      .rate_code      (rate_latch_ff),
      .sample_tick_ff (sample_tick),
      .bucket_tick_ff (bucket_tick),
      .full_rate_ff   (full_rate)
   );

   // polarity bit 3: 0 rising, 1 falling crossing of the level
   assign video_edge = ctrl_word_ff[`CW_VTRIG_POL] ? (below && above_d_ff)
                                                  : (above && !above_d_ff);
   // R17
   assign trig_src = ctrl_word_ff[`CW_VTRIG_EN_N] ? (sweep_strobe && !sweep_d_ff)
                                                 : video_trigger_clock_ff;
   assign trigger  = trig_src && armed && rearm_ok_ff && write_mode && !counting_ff; // R16
   assign store    = write_mode && sample_tick && count_stop_n_ff;
   // extremum latch takes the new sample when it wins, or at bucket start
   assign take_new = full_rate || !ctrl_word_ff[`CW_SAMPLE_DIS_N] || bucket_tick // R13
                     || (ctrl_word_ff[`CW_PIT_SELECT] ? (converter_sample < extremum_ff)
                                                     : (converter_sample > extremum_ff)); // R10

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_word_ff            <= `CW_RESET; // R25
         high_hold_ff            <= 8'hff;
         data_hi_ff              <= 8'h00;
         rate_latch_ff           <= {RATE_W{1'b0}};
         video_level_ff          <= 8'h00;
         post_cnt_ff             <= `POST_TERMINAL;
         trig_addr_ff            <= 15'h0000;
         extremum_ff             <= 8'h00;
         counting_ff             <= 1'b0;
         rearm_ok_ff             <= 1'b0;
         sweep_d_ff              <= 1'b0;
         above_d_ff              <= 1'b0;
         hi_strobe_d_ff          <= 1'b0;
         lo_strobe_d_ff          <= 1'b0;
         host_data_out_ff        <= 8'h00;
         host_data_oe_ff         <= 1'b0;
         mem_write_data_ff       <= 8'h00;
         mem_write_ff            <= 1'b0;
         mem_addr_ff             <= 15'h0000;
         sweep_strobe_release_ff <= 1'b0;
         count_stop_n_ff         <= 1'b0;
         video_trigger_clock_ff  <= 1'b0;
         triggered_ff            <= 1'b0;
         gain_x2_ff              <= 1'b0;
      end else begin
         hi_strobe_d_ff <= high_byte_strobe;
         lo_strobe_d_ff <= low_byte_strobe;
         sweep_d_ff     <= sweep_strobe;
         gain_x2_ff     <= ctrl_word_ff[`CW_GAIN_X2];
         // control word: high byte held, word taken on low byte
         if (hi_pulse && port_select_line == `PORT_CONTROL) begin // R22
            high_hold_ff <= host_data_in;
         end
         if (ctrl_wr) begin // R22
            ctrl_word_ff <= {high_hold_ff, host_data_in};
         end
         if (data_hi) begin
            data_hi_ff <= host_data_in;
         end
         if (data_lo && !ctrl_word_ff[`CW_RATE_LOAD_N] && !write_mode) begin // R7
            rate_latch_ff <= data_word[RATE_W-1:0];
         end
         if (data_lo && !ctrl_word_ff[`CW_VLEVEL_LOAD_N] && !write_mode) begin // R9
            video_level_ff <= host_data_in;
         end
         sweep_strobe_release_ff <= !ctrl_word_ff[`CW_SWEEP_REL_N]; // R8
         // arm must drop before another trigger
         if (!armed) begin // R16
            rearm_ok_ff <= 1'b1;
         end else if (trigger) begin
            rearm_ok_ff <= 1'b0;
         end
         // video trigger clock, sampled with the sample clock
         if (sample_tick) begin // R18
            above_d_ff             <= above;
            video_trigger_clock_ff <= video_edge && !ctrl_word_ff[`CW_VTRIG_EN_N]; // R3
         end else begin
            video_trigger_clock_ff <= 1'b0;
         end
         // post-trigger counter and stop
         if (read_clk_on && data_lo && !ctrl_word_ff[`CW_POST_LOAD_N]) begin // R2
            post_cnt_ff     <= data_word;
            count_stop_n_ff <= (data_word != `POST_TERMINAL);
            counting_ff     <= 1'b0;
            triggered_ff    <= 1'b0;
         end else if (trigger) begin
            trig_addr_ff <= mem_addr_ff; // R14
            counting_ff  <= 1'b1; // R14
            triggered_ff <= 1'b1;
         end else if (counting_ff && store) begin // R15
            if (post_cnt_ff == `POST_TERMINAL - 16'h0001) begin
               count_stop_n_ff <= 1'b0; // R23
               counting_ff     <= 1'b0; // R23
            end
            post_cnt_ff <= post_cnt_ff + 16'h0001;
         end
         // address counter: load, write advance, read post-increment
         mem_write_ff <= 1'b0;
         if (read_clk_on && data_lo && !ctrl_word_ff[`CW_ADDR_LOAD_N]) begin // R1
            mem_addr_ff <= data_word[14:0];
         end else if (store) begin // R21
            if (take_new) begin
               extremum_ff       <= converter_sample;
               mem_write_data_ff <= converter_sample;
               mem_write_ff      <= !ctrl_word_ff[`CW_ADC_WRITE_DIS_N];
            end
            if (full_rate || bucket_tick) begin
               mem_addr_ff <= (mem_addr_ff == `ADDR_WRAP) ? 15'h0000 // R24
                                                          : mem_addr_ff + 15'h0001;
            end
         end else if (read_clk_on && mem_rd_on && lo_pulse && count_stop_n_ff
                      && port_select_line == `PORT_DATA) begin // R4
            mem_addr_ff <= mem_addr_ff + 15'h0001; // R24
         end
         // read path onto host bus, never in write mode
         host_data_oe_ff <= 1'b0;
         if (port_select_line == `PORT_DATA && !write_mode) begin
            if (mem_rd_on && (high_byte_strobe || low_byte_strobe)) begin // R5
               host_data_out_ff <= mem_read_data;
               host_data_oe_ff  <= 1'b1;
            end else if (taddr_rd_on && high_byte_strobe) begin // R6
               host_data_out_ff <= {1'b0, trig_addr_ff[14:8]};
               host_data_oe_ff  <= 1'b1;
            end else if (taddr_rd_on && low_byte_strobe) begin // R6
               host_data_out_ff <= trig_addr_ff[7:0];
               host_data_oe_ff  <= 1'b1;
            end
         end
      end
   end
endmodule // capture_control

// File: sim/host_bus_model.sv
// host side of the byte strobe bus
`timescale 1ns/1ns
module host_bus_model (
   input  wire       sys_clk,
   input  wire [7:0] host_data_out_ff,
   input  wire       host_data_oe_ff,
   output reg        port_select_line,
   output reg        high_byte_strobe,
   output reg        low_byte_strobe,
   output reg  [7:0] host_data_in
);
   initial begin
      port_select_line = 1'b0;
      high_byte_strobe = 1'b0;
      low_byte_strobe = 1'b0;
      host_data_in = 8'h00;
   end
   // one strobe, one high sample, one low sample
   task automatic put_byte(input logic port, input logic hi, input logic [7:0] d);
      @(negedge sys_clk);
      port_select_line = port;
      host_data_in = d;
      if (hi) high_byte_strobe = 1'b1; else low_byte_strobe = 1'b1;
      @(negedge sys_clk);
      high_byte_strobe = 1'b0;
      low_byte_strobe = 1'b0;
      host_data_in = ~d; // bus released, stale value inverted
      @(negedge sys_clk);
   endtask
   task automatic write_word(input logic port, input logic [15:0] w);
      put_byte(port, 1'b1, w[15:8]);
      put_byte(port, 1'b0, w[7:0]);
      @(negedge sys_clk);
   endtask
   task automatic read_byte(input logic hi, output logic [7:0] d, output logic oe);
      @(negedge sys_clk);
      port_select_line = 1'b1;
      if (hi) high_byte_strobe = 1'b1; else low_byte_strobe = 1'b1;
      repeat (2) @(negedge sys_clk);
      d = host_data_out_ff;
      oe = host_data_oe_ff;
      high_byte_strobe = 1'b0;
      low_byte_strobe = 1'b0;
      repeat (2) @(negedge sys_clk);
   endtask
endmodule // host_bus_model

// File: sim/capture_control_props.sv
// assertions on the capture control ports
`timescale 1ns/1ns
module capture_control_props #(parameter RATE_W = 8) (
   input wire logic        sys_clk, arst_n, port_select_line,
   input wire logic        high_byte_strobe, low_byte_strobe, host_data_oe_ff,
   input wire logic [7:0]  host_data_in, host_data_out_ff, converter_sample,
   input wire logic [7:0]  mem_read_data, mem_write_data_ff,
   input wire logic        sweep_strobe, mem_write_ff, sweep_strobe_release_ff,
   input wire logic        count_stop_n_ff, video_trigger_clock_ff, triggered_ff, gain_x2_ff,
   input wire logic [14:0] mem_addr_ff
);
   logic        hs_ff, ls_ff;
   logic [7:0]  hi_ff;
   logic [15:0] cw_ff;
   // shadow of the control word
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         hs_ff <= 1'b0;
         ls_ff <= 1'b0;
         hi_ff <= 8'h00;
         cw_ff <= 16'hfff0;
      end else begin
         hs_ff <= high_byte_strobe;
         ls_ff <= low_byte_strobe;
         if (high_byte_strobe && !hs_ff && !port_select_line) hi_ff <= host_data_in;
         if (low_byte_strobe && !ls_ff && !port_select_line) cw_ff <= {hi_ff, host_data_in};
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   a_release_follows: assert property ($changed(cw_ff[13]) |-> ##[0:2]
      sweep_strobe_release_ff == !cw_ff[13]) else $error("release bit not followed");
   a_write_blocks_read: assert property (cw_ff[0] && $past(cw_ff[0]) |->
      !host_data_oe_ff) else $error("bus driven in write mode");
   a_oe_after_strobe: assert property (host_data_oe_ff |->
      $past(high_byte_strobe) || $past(low_byte_strobe)) else $error("bus driven unasked");
   a_read_needs_enable: assert property (host_data_oe_ff && $past(port_select_line) |->
      !$past(cw_ff[10]) || !$past(cw_ff[11])) else $error("read while disabled");
   a_trig_needs_arm: assert property ($rose(triggered_ff) |->
      $past(cw_ff[1]) && $past(cw_ff[0])) else $error("trigger while disarmed");
   a_stop_holds_addr: assert property (cw_ff[0] && !count_stop_n_ff &&
      !$past(count_stop_n_ff) |=> $stable(mem_addr_ff)) else $error("address moved at stop");
   a_addr_steps_one: assert property (cw_ff[0] && $past(cw_ff[0]) && $changed(mem_addr_ff)
      |-> mem_addr_ff == $past(mem_addr_ff) + 15'h1) else $error("address step wrong");
   a_write_spaced: assert property (mem_write_ff |=> !mem_write_ff)
      else $error("store ticks too close");
   c_trig: cover property ($rose(triggered_ff));
   c_stop: cover property ($fell(count_stop_n_ff));
   c_read: cover property ($rose(host_data_oe_ff));
endmodule // capture_control_props
bind capture_control capture_control_props #(.RATE_W(RATE_W)) i_capture_control_props (.*);

// File: sim/testbench.sv
// self-checking bench for the capture control unit
`timescale 1ns/1ns
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; \
   $display("Error %0t: got %h want %h", $time, a, e); end end
module testbench;
   reg         sys_clk = 1'b0, arst_n = 1'b0, sweep_strobe = 1'b0;
   reg  [7:0]  converter_sample = 8'h3c, mem_read_data = 8'ha5;
   wire        port_select_line, high_byte_strobe, low_byte_strobe, host_data_oe_ff;
   wire [7:0]  host_data_in, host_data_out_ff, mem_write_data_ff;
   wire        mem_write_ff, sweep_strobe_release_ff, count_stop_n_ff;
   wire        video_trigger_clock_ff, triggered_ff, gain_x2_ff;
   wire [14:0] mem_addr_ff;
   integer     fails = 0, checks = 0, n, w;
   logic [7:0] b, h;
   logic       o;
   logic [14:0] ta, sa;
   capture_control i_capture_control (.*);
   host_bus_model i_host_bus_model (.*);
   always #20 sys_clk = ~sys_clk;
   task tally_and_finish;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task wr(input logic p, input logic [15:0] w);
      i_host_bus_model.write_word(p, w);
   endtask
   initial begin
      #2000000;
      fails++;
      tally_and_finish;
   end
   initial begin
      repeat (10) @(negedge sys_clk);
      arst_n = 1'b1;
      repeat (2) @(negedge sys_clk);
      `CHK(count_stop_n_ff, 1'b0)
      `CHK(sweep_strobe_release_ff, 1'b0)
      `CHK(triggered_ff, 1'b0)
      $display("test reset done");
      wr(1'b0, 16'hdff4);
      `CHK(sweep_strobe_release_ff, 1'b1)
      `CHK(gain_x2_ff, 1'b1)
      wr(1'b0, 16'hfd70);
      wr(1'b1, 16'hfff0);
      `CHK(count_stop_n_ff, 1'b1)
      wr(1'b0, 16'hfff0);
      wr(1'b1, 16'hffff);
      `CHK(count_stop_n_ff, 1'b1)
      $display("test post counter done");
      wr(1'b0, 16'hfdb0);
      wr(1'b1, 16'h1234);
      `CHK(mem_addr_ff, 15'h1234)
      wr(1'b0, 16'hfff0);
      wr(1'b1, 16'h0100);
      `CHK(mem_addr_ff, 15'h1234)
      wr(1'b0, 16'hf9f0);
      i_host_bus_model.read_byte(1'b0, b, o);
      `CHK(o, 1'b1)
      `CHK(b, 8'ha5)
      `CHK(mem_addr_ff, 15'h1235)
      wr(1'b0, 16'hfdf0);
      i_host_bus_model.read_byte(1'b0, b, o);
      `CHK(o, 1'b0)
      $display("test host reads done");
      wr(1'b0, 16'hfd70);
      wr(1'b1, 16'hfff0);
      wr(1'b0, 16'hffd1);
      wr(1'b0, 16'hffd3);
      @(negedge sys_clk);
      ta = mem_addr_ff;
      sweep_strobe = 1'b1;
      n = 0;
      w = 0;
      while (count_stop_n_ff !== 1'b0 && n < 400) begin
         @(negedge sys_clk);
         n++;
         if (mem_write_ff === 1'b1) w++;
      end
      if (n == 400) fails++;
      `CHK(triggered_ff, 1'b1)
      `CHK(w, 16)
      `CHK(mem_write_data_ff, 8'h3c)
      sweep_strobe = 1'b0;
      sa = mem_addr_ff;
      `CHK(sa, ta + 15'h0010)
      repeat (2) @(negedge sys_clk);
      sweep_strobe = 1'b1;
      repeat (4) @(negedge sys_clk);
      `CHK(mem_addr_ff, sa)
      wr(1'b0, 16'hf7f0);
      i_host_bus_model.read_byte(1'b1, h, o);
      i_host_bus_model.read_byte(1'b0, b, o);
      `CHK({h[6:0], b}, ta)
      wr(1'b0, 16'hfd70);
      wr(1'b1, 16'hfff0);
      wr(1'b0, 16'hfdb0);
      wr(1'b1, {1'b0, ta});
      `CHK(mem_addr_ff, ta)
      $display("test trigger done");
      wr(1'b0, 16'hbff0);
      wr(1'b1, 16'h0050);
      wr(1'b0, 16'hfed1);
      wr(1'b0, 16'hfed3);
      converter_sample = 8'h60;
      n = 0;
      w = 0;
      while (triggered_ff !== 1'b1 && n < 20) begin
         @(negedge sys_clk);
         n++;
         if (video_trigger_clock_ff === 1'b1) w++;
      end
      `CHK(w, 1)
      `CHK(triggered_ff, 1'b1)
      $display("test video trigger done");
      tally_and_finish;
   end
endmodule // testbench
